//--- rqh_mac_model.sv
`timescale 1ns/1ps
module rqh_mac_model (
	input wire clock,
	input wire go,
	input wire [15:0] status,
	input wire rx_ready,
	output reg rx_word_valid = 1'b0,
	output reg [15:0] rx_word = 16'h0000,
	output reg rx_frame_end = 1'b0,
	output reg [15:0] rx_frame_status = 16'h0000,
	output reg [11:0] rx_frame_bytes = 12'h000,
	output reg busy = 1'b0
);
	// ****
	// frame source: three words then the closing end
	// ****
	integer i, k;
	reg stuck = 1'b0;
	// held until an edge that sees rx_ready, since words are dropped otherwise
	// a wait that runs out leaves busy high so the bench counts it
	task push;
		begin
			k = 0;
			do begin
				@(posedge clock);
				k = k + 1;
			end while (rx_ready !== 1'b1 && k < 60);
			if (rx_ready !== 1'b1)
				stuck = 1'b1;
			#1;
		end
	endtask
	always @(posedge go) begin
		busy = 1'b1;
		for (i = 0; i < 3; i = i + 1) begin
			rx_word_valid = 1'b1;
			rx_word = 16'hd000 | i[15:0];
			push;
		end
		rx_word_valid = 1'b0;
		rx_word = ~rx_word;
		rx_frame_end = 1'b1;
		rx_frame_status = status;
		rx_frame_bytes = 12'h006;
		push;
		rx_frame_end = 1'b0;
		rx_frame_status = ~status;
		busy = stuck;
	end
endmodule // rqh_mac_model

//--- rqh_receive_queue.v
`timescale 1ns/1ps
// Notes on behaviour
// [R1] control one bit 10 enables receive flow control
// [R2] control one bit 0 enables receive block operation
// [R3] control two selects checksum checks on ICMP, UDP, TCP, IP
// [R4] header status of current frame readable as 16 bits
// [R5] byte count of current frame readable as 12 bits
// [R6] queue command bit 3 starts host buffer access; host sets it first
// [R7] queue command bit 4 releases frames automatically after host reads
// [R8] bit 5 enables frame count threshold, bit 10 reports it
// [R9] bit 6 enables byte count threshold, bit 11 reports it
// [R10] bit 7 enables duration threshold, bit 12 reports it
// [R11] bit 9 inserts two bytes ahead of frame data for alignment
// [R12] pointer bit 14 advances buffer address on each data access
// [R13] frame age counted in microseconds beyond threshold raises rx interrupt
// [R14] buffered bytes beyond threshold raise rx interrupt and status
// [R15] buffered frames beyond low byte threshold raise rx interrupt and status
// [R16] upper byte of frame count holds frame total at rx interrupt
// [R17] interrupt enable bit 13 gates the receive interrupt
// [R18] status bits clear when written with ones; only bit 13 here, and not while a threshold fires
// [R19] first data read after access start is dummy; host reads to dword
// [R20] frame count read loads header; reading both headers loads next
// [R21] frame stored as status word, byte count word, then data
// [R22] interrupt output high while an enabled status bit is set
`include "rqh_receive_queue_regs.vh"

module rqh_receive_queue (
	input wire clock,
	input wire arst_n,
	input wire [7:0] host_addr,
	input wire host_wr,
	input wire host_rd,
	input wire [1:0] host_be,
	input wire [15:0] host_wdata,
	output reg [15:0] host_rdata,
	output reg host_rvalid,
	output reg irq,
	input wire rx_word_valid,
	input wire [15:0] rx_word,
	input wire rx_frame_end,
	input wire [15:0] rx_frame_status,
	input wire [11:0] rx_frame_bytes,
	output reg rx_ready,
	output reg flow_ctl_en,
	output reg rx_block_en,
	output reg [15:0] csum_check_sel
);

	// ****************************************************************
	// storage
	// ****************************************************************
	reg [15:0] mem [0:`RQH_MEM_WORDS-1];
	reg [15:0] hdr_stat [0:`RQH_HDR_DEPTH-1];
	reg [11:0] hdr_bytes [0:`RQH_HDR_DEPTH-1];
	reg [9:0] hdr_base [0:`RQH_HDR_DEPTH-1];
	reg [9:0] hdr_next [0:`RQH_HDR_DEPTH-1];

	reg [15:0] ctl1_q;
	reg [15:0] ctl2_q;
	reg [15:0] qcmd_q;
	reg [15:0] ptr_q;
	reg [15:0] dur_thr_q;
	reg [15:0] byte_thr_q;
	reg [15:0] ien_q;
	reg [15:0] isr_q;
	reg [7:0] fthr_q;
	reg [7:0] fsnap_q;
	reg [15:0] cur_stat_q;
	reg [11:0] cur_bytes_q;
	reg [9:0] fstart_q;
	reg [9:0] fcnt_words_q;
	reg [9:0] tail_q;
	reg [4:0] hw_q;
	reg [4:0] hr_q;
	reg [4:0] hp_q;
	reg [16:0] total_bytes_q;
	reg [15:0] age_q;
	reg [6:0] tick_q;
	reg dummy_q;
	reg seen_stat_q;
	reg seen_bytes_q;
	reg fst_q;
	reg bst_q;
	reg dst_q;

	wire wr_16 = host_wr & (&host_be);
	wire [4:0] frames = hw_q - hr_q;
	wire have_frame = (frames != 5'd0);
	wire [3:0] hr_i = hr_q[3:0];
	wire [9:0] align_words = {9'd0, qcmd_q[`RQH_QC_IP_ALIGN]};
	wire [9:0] wr_addr = fstart_q + 10'd2 + align_words + fcnt_words_q; // [R11]
	wire [9:0] used = wr_addr - tail_q;
	wire [9:0] rd_addr = hdr_base[hr_i] + ptr_q[10:1];
	wire [15:0] new_qcmd = (qcmd_q & ~`RQH_QC_WR_MASK) | (host_wdata & `RQH_QC_WR_MASK);
	wire dequeue = wr_16 && (host_addr == `RQH_OFS_QUEUE_CMD) && qcmd_q[`RQH_QC_DMA_START]
		&& !host_wdata[`RQH_QC_DMA_START] && qcmd_q[`RQH_QC_AUTO_DEQ] && have_frame; // [R7]
	wire dma_rise = wr_16 && (host_addr == `RQH_OFS_QUEUE_CMD)
		&& !qcmd_q[`RQH_QC_DMA_START] && host_wdata[`RQH_QC_DMA_START]; // [R6]
	wire data_rd = host_rd && (host_addr == `RQH_OFS_DATA) && qcmd_q[`RQH_QC_DMA_START];
	wire data_wr = wr_16 && (host_addr == `RQH_OFS_DATA) && qcmd_q[`RQH_QC_DMA_START];
	wire accept_word = rx_word_valid && rx_ready;
	wire accept_end = rx_frame_end && rx_ready;
	wire fire_f = qcmd_q[`RQH_QC_FCNT_EN] && ({3'd0, frames} > fthr_q); // [R15]
	wire fire_b = qcmd_q[`RQH_QC_BCNT_EN] && (total_bytes_q > {1'b0, byte_thr_q}); // [R14]
	wire fire_d = qcmd_q[`RQH_QC_DUR_EN] && have_frame && (age_q > dur_thr_q); // [R13]
	wire rx_event = fire_f | fire_b | fire_d;
	wire isr_clr13 = wr_16 && (host_addr == `RQH_OFS_INT_STAT) && host_wdata[`RQH_INT_RX];
	wire tick_wrap = ({25'd0, tick_q} == (`RQH_TICK_CYCLES - 1));

	// ****************************************************************
	// frame intake and buffer memory
	// ****************************************************************
	always @(posedge clock) begin
		if (accept_word) begin
			mem[wr_addr] <= rx_word;
		end
		if (accept_end) begin
			mem[fstart_q] <= rx_frame_status; // [R21]
			mem[fstart_q + 10'd1] <= {4'h0, rx_frame_bytes}; // [R21]
			hdr_stat[hw_q[3:0]] <= rx_frame_status;
			hdr_bytes[hw_q[3:0]] <= rx_frame_bytes;
			hdr_base[hw_q[3:0]] <= fstart_q;
			hdr_next[hw_q[3:0]] <= wr_addr;
		end
		if (data_wr && !dummy_q) begin
			mem[rd_addr] <= host_wdata;
		end
	end

	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			fstart_q <= 10'd0;
			fcnt_words_q <= 10'd0;
			hw_q <= 5'd0;
			rx_ready <= 1'b0;
		end else begin
			if (accept_end) begin
				fstart_q <= wr_addr;
				fcnt_words_q <= 10'd0;
				hw_q <= hw_q + 5'd1;
			end else if (accept_word) begin
				fcnt_words_q <= fcnt_words_q + 10'd1;
			end
			// margin covers header words and the cycle of flop latency on ready
			rx_ready <= (used < (10'h3FF - `RQH_FILL_MARGIN)) && (frames < 5'd15);
		end
	end

	// ****************************************************************
	// host registers and buffer access
	// ****************************************************************
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			ctl1_q <= `RQH_RST_WORD;
			ctl2_q <= `RQH_RST_WORD;
			qcmd_q <= `RQH_RST_WORD;
			ptr_q <= `RQH_RST_WORD;
			dur_thr_q <= `RQH_RST_WORD;
			byte_thr_q <= `RQH_RST_WORD;
			ien_q <= `RQH_RST_WORD;
			fthr_q <= 8'h00;
			dummy_q <= 1'b0;
			host_rdata <= 16'h0000;
			host_rvalid <= 1'b0;
			cur_stat_q <= 16'h0000;
			cur_bytes_q <= 12'h000;
			hp_q <= 5'd0;
			seen_stat_q <= 1'b0;
			seen_bytes_q <= 1'b0;
		end else begin
			host_rvalid <= host_rd;
			if (host_wr) begin
				if (host_addr == `RQH_OFS_RX_CTRL_ONE) begin
					if (host_be[0]) ctl1_q[7:0] <= host_wdata[7:0];
					if (host_be[1]) ctl1_q[15:8] <= host_wdata[15:8];
				end else if (host_addr == `RQH_OFS_RX_CTRL_TWO) begin
					if (host_be[0]) ctl2_q[7:0] <= host_wdata[7:0];
					if (host_be[1]) ctl2_q[15:8] <= host_wdata[15:8];
				end else if (host_addr == `RQH_OFS_QUEUE_CMD && wr_16) begin
					qcmd_q <= new_qcmd;
				end else if (host_addr == `RQH_OFS_BUF_PTR && wr_16) begin
					ptr_q <= host_wdata & `RQH_PTR_WR_MASK;
				end else if (host_addr == `RQH_OFS_DUR_THR && wr_16) begin
					dur_thr_q <= host_wdata;
				end else if (host_addr == `RQH_OFS_BYTE_THR && wr_16) begin
					byte_thr_q <= host_wdata;
				end else if (host_addr == `RQH_OFS_INT_EN && wr_16) begin
					ien_q <= host_wdata;
				end else if (host_addr == `RQH_OFS_FRAME_CNT && host_be[0]) begin
					fthr_q <= host_wdata[7:0];
				end
			end
			if (dma_rise) begin
				dummy_q <= 1'b1; // [R19]
			end else if (data_rd || data_wr) begin
				dummy_q <= 1'b0;
				if (!dummy_q && ptr_q[`RQH_PTR_AUTO_INC]) begin
					ptr_q[10:0] <= ptr_q[10:0] + 11'd2; // [R12]
				end
			end
			if (dequeue) begin
				ptr_q[10:0] <= 11'd0;
			end
			if (host_rd) begin
				if (host_addr == `RQH_OFS_RX_CTRL_ONE) begin
					host_rdata <= ctl1_q;
				end else if (host_addr == `RQH_OFS_RX_CTRL_TWO) begin
					host_rdata <= ctl2_q;
				end else if (host_addr == `RQH_OFS_HDR_STATUS) begin
					host_rdata <= cur_stat_q; // [R4]
				end else if (host_addr == `RQH_OFS_HDR_BYTES) begin
					host_rdata <= {4'h0, cur_bytes_q}; // [R5]
				end else if (host_addr == `RQH_OFS_QUEUE_CMD) begin
					host_rdata <= {3'b000, dst_q, bst_q, fst_q, qcmd_q[9:0]}; // [R8] [R9] [R10]
				end else if (host_addr == `RQH_OFS_BUF_PTR) begin
					host_rdata <= ptr_q;
				end else if (host_addr == `RQH_OFS_DUR_THR) begin
					host_rdata <= dur_thr_q;
				end else if (host_addr == `RQH_OFS_BYTE_THR) begin
					host_rdata <= byte_thr_q;
				end else if (host_addr == `RQH_OFS_INT_EN) begin
					host_rdata <= ien_q;
				end else if (host_addr == `RQH_OFS_INT_STAT) begin
					host_rdata <= isr_q;
				end else if (host_addr == `RQH_OFS_FRAME_CNT) begin
					host_rdata <= {fsnap_q, fthr_q}; // [R16]
				end else if (host_addr == `RQH_OFS_DATA) begin
					// the read made while the pipe primes returns zero and is thrown away by the host
					host_rdata <= (data_rd && !dummy_q) ? mem[rd_addr] : 16'h0000; // [R19]
				end else begin
					host_rdata <= 16'h0000;
				end
			end
			// header readout walks frames without releasing them
			if (host_rd && host_addr == `RQH_OFS_FRAME_CNT) begin
				cur_stat_q <= hdr_stat[hr_i]; // [R20]
				cur_bytes_q <= hdr_bytes[hr_i];
				hp_q <= hr_q + 5'd1;
				seen_stat_q <= 1'b0;
				seen_bytes_q <= 1'b0;
			end else if ((seen_stat_q || (host_rd && host_addr == `RQH_OFS_HDR_STATUS))
				&& (seen_bytes_q || (host_rd && host_addr == `RQH_OFS_HDR_BYTES))) begin
				cur_stat_q <= (hp_q != hw_q) ? hdr_stat[hp_q[3:0]] : 16'h0000; // [R20]
				cur_bytes_q <= (hp_q != hw_q) ? hdr_bytes[hp_q[3:0]] : 12'h000;
				hp_q <= (hp_q != hw_q) ? hp_q + 5'd1 : hp_q;
				seen_stat_q <= 1'b0;
				seen_bytes_q <= 1'b0;
			end else if (host_rd && host_addr == `RQH_OFS_HDR_STATUS) begin
				seen_stat_q <= 1'b1;
			end else if (host_rd && host_addr == `RQH_OFS_HDR_BYTES) begin
				seen_bytes_q <= 1'b1;
			end
		end
	end

	// ****************************************************************
	// release, thresholds and interrupt
	// ****************************************************************
	always @(posedge clock or negedge arst_n) begin
		if (!arst_n) begin
			tail_q <= 10'd0;
			hr_q <= 5'd0;
			total_bytes_q <= 17'd0;
			age_q <= 16'h0000;
			tick_q <= 7'd0;
			fst_q <= 1'b0;
			bst_q <= 1'b0;
			dst_q <= 1'b0;
			isr_q <= 16'h0000;
			fsnap_q <= 8'h00;
			irq <= 1'b0;
			flow_ctl_en <= 1'b0;
			rx_block_en <= 1'b0;
			csum_check_sel <= 16'h0000;
		end else begin
			flow_ctl_en <= ctl1_q[`RQH_RC1_FLOW_EN]; // [R1]
			rx_block_en <= ctl1_q[`RQH_RC1_BLOCK_EN]; // [R2]
			csum_check_sel <= ctl2_q; // [R3]
			if (dequeue) begin
				tail_q <= hdr_next[hr_i]; // [R7]
				hr_q <= hr_q + 5'd1;
			end
			total_bytes_q <= total_bytes_q
				+ (accept_end ? {5'd0, rx_frame_bytes} : 17'd0)
				- (dequeue ? {5'd0, hdr_bytes[hr_i]} : 17'd0);
			// age follows the oldest frame; restarts when it leaves
			tick_q <= tick_wrap ? 7'd0 : tick_q + 7'd1;
			if (dequeue || !have_frame) begin
				age_q <= 16'h0000;
			end else if (tick_wrap && age_q != 16'hFFFF) begin
				age_q <= age_q + 16'h0001; // [R13]
			end
			fst_q <= fire_f; // [R8]
			bst_q <= fire_b; // [R9]
			dst_q <= fire_d; // [R10]
			if (rx_event) begin
				isr_q[`RQH_INT_RX] <= 1'b1; // [R13] [R14] [R15]
				if (!isr_q[`RQH_INT_RX]) begin
					fsnap_q <= {3'd0, frames}; // [R16]
				end
			end else if (isr_clr13) begin
				isr_q[`RQH_INT_RX] <= 1'b0; // [R18]
			end
			irq <= |(isr_q & ien_q); // [R17] [R22]
		end
	end

endmodule // rqh_receive_queue

//--- rqh_receive_queue_properties.sv
`timescale 1ns/1ps
module rqh_receive_queue_checker (
	input wire clock,
	input wire arst_n,
	input wire [7:0] host_addr,
	input wire host_wr,
	input wire host_rd,
	input wire [1:0] host_be,
	input wire [15:0] host_wdata,
	input wire [15:0] host_rdata,
	input wire host_rvalid,
	input wire irq,
	input wire flow_ctl_en,
	input wire rx_block_en,
	input wire [15:0] csum_check_sel
);
	// ****
	// host port properties
	// ****
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!arst_n);
	wire full_wr = host_wr && host_be == 2'h3;
	a_rd_answer: assert property (host_rd |=> host_rvalid)
		else $error("read not answered");
	a_rvalid_cause: assert property (host_rvalid |-> $past(host_rd))
		else $error("answer without read");
	a_flow_copy: assert property (full_wr && host_addr == 8'h74 |-> ##2
		flow_ctl_en == $past(host_wdata[10], 2)) else $error("flow enable wrong");
	a_block_copy: assert property (full_wr && host_addr == 8'h74 |-> ##2
		rx_block_en == $past(host_wdata[0], 2)) else $error("block enable wrong");
	a_csum_copy: assert property (full_wr && host_addr == 8'h76 |-> ##2
		csum_check_sel == $past(host_wdata, 2)) else $error("checksum select wrong");
	a_irq_gate: assert property (full_wr && host_addr == 8'h90 && !host_wdata[13]
		|-> ##2 !irq) else $error("masked interrupt seen");
	a_unmapped_zero: assert property (host_rd && host_addr == 8'h00 |=> host_rdata == 16'h0000)
		else $error("unmapped read not zero");
	a_rdata_hold: assert property (!host_rvalid |-> $stable(host_rdata))
		else $error("read data moved");
	c_irq: cover property ($rose(irq));
	c_flow: cover property ($rose(flow_ctl_en));
	c_read: cover property (host_rvalid && host_rdata[10]);
endmodule // rqh_receive_queue_checker

bind rqh_receive_queue rqh_receive_queue_checker chk_u (.clock(clock), .arst_n(arst_n),
	.host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd), .host_be(host_be),
	.host_wdata(host_wdata), .host_rdata(host_rdata), .host_rvalid(host_rvalid), .irq(irq),
	.flow_ctl_en(flow_ctl_en), .rx_block_en(rx_block_en), .csum_check_sel(csum_check_sel));

//--- rqh_receive_queue_regs.vh
`ifndef RQH_RECEIVE_QUEUE_REGS_VH
`define RQH_RECEIVE_QUEUE_REGS_VH

// ****************************************************************
// register offsets (byte addresses on the host port)
// ****************************************************************
`define RQH_OFS_RX_CTRL_ONE 8'h74
`define RQH_OFS_RX_CTRL_TWO 8'h76
`define RQH_OFS_HDR_STATUS 8'h7C
`define RQH_OFS_HDR_BYTES 8'h7E
`define RQH_OFS_QUEUE_CMD 8'h82
`define RQH_OFS_BUF_PTR 8'h86
`define RQH_OFS_DUR_THR 8'h8C
`define RQH_OFS_BYTE_THR 8'h8E
`define RQH_OFS_INT_EN 8'h90
`define RQH_OFS_INT_STAT 8'h92
`define RQH_OFS_FRAME_CNT 8'h9C
`define RQH_OFS_DATA 8'hC0

// ****************************************************************
// field positions
// ****************************************************************
`define RQH_RC1_BLOCK_EN 0
`define RQH_RC1_FLOW_EN 10
`define RQH_QC_DMA_START 3
`define RQH_QC_AUTO_DEQ 4
`define RQH_QC_FCNT_EN 5
`define RQH_QC_BCNT_EN 6
`define RQH_QC_DUR_EN 7
`define RQH_QC_IP_ALIGN 9
`define RQH_QC_FCNT_ST 10
`define RQH_QC_BCNT_ST 11
`define RQH_QC_DUR_ST 12
`define RQH_PTR_AUTO_INC 14
`define RQH_INT_RX 13

// ****************************************************************
// reset values, sizes and timing
// ****************************************************************
`define RQH_RST_WORD 16'h0000
`define RQH_QC_WR_MASK 16'h02F8
`define RQH_PTR_WR_MASK 16'h47FF
`define RQH_MEM_WORDS 1024
`define RQH_HDR_DEPTH 16
`define RQH_FILL_MARGIN 10'h008
`define RQH_CLK_MHZ 100
`define RQH_TICK_US 1
`define RQH_TICK_CYCLES (`RQH_TICK_US * `RQH_CLK_MHZ)

`endif

//--- tb_rqh_receive_queue.sv
`timescale 1ns/1ps
module tb_rqh_receive_queue;
	reg clock = 1'b0, arst_n = 1'b0, host_wr = 1'b0, host_rd = 1'b0, mac_go = 1'b0;
	reg [7:0] host_addr = 8'h00;
	reg [1:0] host_be = 2'h3;
	reg [15:0] host_wdata = 16'h0000, mac_status = 16'h0000;
	integer error_cnt = 0, comparisons = 0, i;
	wire [15:0] host_rdata, rx_word, rx_frame_status, csum_check_sel;
	wire [11:0] rx_frame_bytes;
	wire host_rvalid, irq, rx_word_valid, rx_frame_end, rx_ready, flow_ctl_en, rx_block_en, busy;
	rqh_receive_queue dut_u (.clock(clock), .arst_n(arst_n), .host_addr(host_addr),
		.host_wr(host_wr), .host_rd(host_rd), .host_be(host_be), .host_wdata(host_wdata),
		.host_rdata(host_rdata), .host_rvalid(host_rvalid), .irq(irq),
		.rx_word_valid(rx_word_valid), .rx_word(rx_word), .rx_frame_end(rx_frame_end),
		.rx_frame_status(rx_frame_status), .rx_frame_bytes(rx_frame_bytes), .rx_ready(rx_ready),
		.flow_ctl_en(flow_ctl_en), .rx_block_en(rx_block_en), .csum_check_sel(csum_check_sel));
	rqh_mac_model mac_u (.clock(clock), .go(mac_go), .status(mac_status), .rx_ready(rx_ready),
		.rx_word_valid(rx_word_valid), .rx_word(rx_word), .rx_frame_end(rx_frame_end),
		.rx_frame_status(rx_frame_status), .rx_frame_bytes(rx_frame_bytes), .busy(busy));
	// ****
	// bus tasks and scenarios
	// ****
	initial begin
		forever #5 clock = ~clock;
	end
	task close_out;
		$display("errors=%0d comparisons=%0d", error_cnt, comparisons);
		if (error_cnt == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	task chk(input [15:0] got, input [15:0] exp);
		comparisons = comparisons + 1;
		if (got !== exp) begin
			error_cnt = error_cnt + 1;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task idle(input integer n);
		repeat (n) @(posedge clock);
		#1;
	endtask
	task wr(input [7:0] a, input [15:0] d);
		idle(1);
		host_addr = a;
		host_wdata = d;
		host_wr = 1'b1;
		idle(1);
		host_wr = 1'b0;
	endtask
	task rc(input [7:0] a, input [15:0] e);
		idle(1);
		host_addr = a;
		host_rd = 1'b1;
		idle(1);
		host_rd = 1'b0;
		chk(host_rdata, e);
	endtask
	// the model is polled under a bound so a stuck rx_ready cannot hang the run
	task send_frame(input [15:0] s);
		integer n;
		mac_status = s;
		idle(1);
		mac_go = 1'b1;
		idle(1);
		mac_go = 1'b0;
		for (n = 0; n < 50 && busy; n = n + 1)
			idle(1);
		if (busy) begin
			error_cnt = error_cnt + 1;
			close_out;
		end
		idle(2);
	endtask
	task t_ctrl;
		rc(8'h74, 16'h0000);
		rc(8'h00, 16'h0000);
		wr(8'h90, 16'h0000);
		wr(8'h74, 16'h0401);
		idle(1);
		chk({14'h0000, flow_ctl_en, rx_block_en}, 16'h0003);
		host_be = 2'h1;
		wr(8'h74, 16'h0000);
		host_be = 2'h3;
		idle(1);
		chk({14'h0000, flow_ctl_en, rx_block_en}, 16'h0002);
		wr(8'h76, 16'h5a5a);
		idle(1);
		chk(csum_check_sel, 16'h5a5a);
		rc(8'h76, 16'h5a5a);
	endtask
	task t_frame;
		send_frame(16'h8123);
		wr(8'h9c, 16'h0000);
		wr(8'h90, 16'h2000);
		wr(8'h82, 16'h0020);
		idle(4);
		rc(8'h82, 16'h0420);
		chk({15'h0000, irq}, 16'h0001);
		rc(8'h9c, 16'h0100);
		rc(8'h7c, 16'h8123);
		rc(8'h7e, 16'h0006);
		rc(8'h7c, 16'h0000);
		wr(8'h92, 16'hffff);
		idle(3);
		chk({15'h0000, irq}, 16'h0001);
		wr(8'h82, 16'h0000);
		idle(3);
		wr(8'h92, 16'hffff);
		idle(3);
		chk({15'h0000, irq}, 16'h0000);
		rc(8'h92, 16'h0000);
	endtask
	task t_data;
		wr(8'h8e, 16'h0005);
		wr(8'h82, 16'h0058);
		idle(3);
		rc(8'h82, 16'h0858);
		wr(8'h86, 16'h4000);
		rc(8'hc0, 16'h0000);
		rc(8'hc0, 16'h8123);
		rc(8'hc0, 16'h0006);
		for (i = 0; i < 3; i = i + 1)
			rc(8'hc0, 16'hd000 | i[15:0]);
		wr(8'h82, 16'h0050);
		idle(3);
		rc(8'h82, 16'h0050);
	endtask
	task t_dur;
		wr(8'h82, 16'h0280);
		wr(8'h8c, 16'h0002);
		send_frame(16'h0042);
		rc(8'h82, 16'h0280);
		idle(400);
		rc(8'h82, 16'h1280);
		wr(8'h82, 16'h0288);
		wr(8'h86, 16'h4006);
		rc(8'hc0, 16'h0000);
		rc(8'hc0, 16'hd000);
	endtask
	initial begin
		idle(3);
		arst_n = 1'b1;
		t_ctrl;
		t_frame;
		t_data;
		t_dur;
		close_out;
	end
endmodule // tb_rqh_receive_queue
